//--- include/nmpc_cfg.svh
// nmpc_cfg.svh: offsets, field positions, reset values, command codes and timing counts
// assumes inclusion by bare name from include/
`ifndef NMPC_CFG_SVH
`define NMPC_CFG_SVH

// register offsets (byte addresses)
`define NMPC_OFF_CTRL      12'h000
`define NMPC_OFF_ADDR0     12'h004
`define NMPC_OFF_ADDR1     12'h008
`define NMPC_OFF_DATA      12'h00c
`define NMPC_OFF_STATUS    12'h010
`define NMPC_OFF_RESULT    12'h014
`define NMPC_OFF_LEN       12'h018

// control field positions
`define NMPC_CTRL_GO       0
`define NMPC_CTRL_MULTI    1
`define NMPC_CTRL_CACHE    2
`define NMPC_CTRL_LAST     3
`define NMPC_CTRL_RESET    4

// status field positions
`define NMPC_ST_BUSY       0
`define NMPC_ST_DONE       1
`define NMPC_ST_ERR        2
`define NMPC_ST_RB         3

// reset values
`define NMPC_LEN_RST       12'h800

// flash commands
`define NMPC_CMD_SETUP     8'h80
`define NMPC_CMD_SETUP2    8'h81
`define NMPC_CMD_PROG      8'h10
`define NMPC_CMD_DUMMY     8'h11
`define NMPC_CMD_CACHE     8'h15
`define NMPC_CMD_STAT      8'h70
`define NMPC_CMD_STAT2     8'h71
`define NMPC_CMD_RESET     8'hff

// status byte bits (I/O1 is bit 0)
`define NMPC_SB_FAIL       0
`define NMPC_SB_RDY        5
`define NMPC_SB_CRDY       6

// address cycles and page-in-block width
`define NMPC_ADDR_CYC      5
`define NMPC_PAGE_BITS     6

// strobe phase length: 25 ns minimum, rounded up at 25 ns per cycle
`define NMPC_CLK_NS        25
`define NMPC_STROBE_NS     25
`define NMPC_STROBE_CYC    ((`NMPC_STROBE_NS + `NMPC_CLK_NS - 1) / `NMPC_CLK_NS)

`endif

//--- include/nmpc_pkg.sv
// nmpc_pkg: types shared by the flash program controller
// assumes nmpc_cfg.svh is on the include path
package nmpc_pkg;
	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       ce_n;
		logic       we_n;
		logic       re_n;
		logic [7:0] dq_out;
		logic       dq_oe_n;
	} nmpc_pins_type;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} nmpc_apb_req_type;

	typedef enum logic [3:0] {
		nmpc_idle, nmpc_cmd1, nmpc_addr, nmpc_data, nmpc_cmd2,
		nmpc_wait_rb, nmpc_stat_cmd, nmpc_stat_rd, nmpc_reset
	} nmpc_state_type;
endpackage : nmpc_pkg

//--- src/nmpc_ctrl.sv
// nmpc_ctrl: host-side controller for cached and two-district page program
// assumes an APB master, a byte-wide flash on the pins, ready_busy_pin async
//
// The APB register port and the register offsets were left to the implementer.
`include "nmpc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module nmpc_ctrl (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// flash pins
	output nmpc_pkg::nmpc_pins_type    flash_pins,
	input  wire logic [7:0]            dq_in,
	input  wire logic                  ready_busy_pin
);
	import nmpc_pkg::*;

	typedef struct packed {
		nmpc_state_type state;
		logic [1:0]  phase;
		logic [11:0] cnt;
		logic        second;
		logic        multi;
		logic        cache;
		logic        last;
		logic        busy;
		logic        done;
		logic        err;
		logic [39:0] addr0;
		logic [39:0] addr1;
		logic [11:0] len;
		logic [11:0] wptr;
		logic [10:0] last_blk;
		logic        chain;
		logic [7:0]  result;
		logic [2:0]  rb_sync;
		logic        rb;
		nmpc_pins_type pins;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} nmpc_regs_type;

	nmpc_regs_type r, next_r;
	logic [7:0]    mem_q;
	logic          mem_we;

	// block number sits above the page-in-block bits of the row
	function automatic logic [10:0] blk_of(input logic [39:0] a);
		blk_of = a[16+`NMPC_PAGE_BITS +: 11];
	endfunction : blk_of

	function automatic logic [7:0] addr_byte(input logic [39:0] a,
	                                         input logic [11:0] i);
		addr_byte = a[i[2:0]*8 +: 8];
	endfunction : addr_byte

	nmpc_page_mem u_mem (
		.pclk    (pclk),
		.wr_en   (mem_we),
		.wr_addr (r.wptr),
		.wr_data (pwdata[7:0]),
		.rd_addr (next_r.cnt),
		.rd_data (mem_q)
	);

	assign mem_we = psel && penable && pwrite && !r.pready
	                && paddr == `NMPC_OFF_DATA;

	always_comb begin
		logic [7:0]  cmd;
		logic        acc;
		logic        step;
		logic [39:0] a;
		logic [10:0] blk0;
		logic [10:0] blk1;
		blk0   = blk_of(r.addr0);
		blk1   = blk_of(r.addr1);
		next_r = r;
		cmd    = 8'h00;
		acc    = psel && penable && !r.pready;
		a      = r.second ? r.addr1 : r.addr0;
		next_r.pready  = acc;
		next_r.pslverr = 1'b0;
		next_r.rb_sync = {r.rb_sync[1:0], ready_busy_pin};
		if (r.rb_sync[2] == r.rb_sync[1]) begin
			next_r.rb = r.rb_sync[2];
		end
		step = (r.phase == 2'd1);
		if (acc && pwrite) begin
			unique case (paddr)
			`NMPC_OFF_CTRL: begin
				if (pwdata[`NMPC_CTRL_RESET]) begin
					next_r.state = nmpc_reset;
					next_r.phase = 2'd0;
					next_r.busy  = 1'b1;
					next_r.chain = 1'b0;
				end else if (pwdata[`NMPC_CTRL_GO] && !r.busy) begin
					next_r.multi = pwdata[`NMPC_CTRL_MULTI];
					next_r.cache = pwdata[`NMPC_CTRL_CACHE];
					next_r.last  = pwdata[`NMPC_CTRL_LAST];
					next_r.busy  = 1'b1;
					next_r.done  = 1'b0;
					next_r.err   = 1'b0;
					next_r.state = nmpc_cmd1;
					next_r.phase = 2'd0;
					next_r.second = 1'b0;
					// a cached chain to a new block is refused
					if (r.chain && blk0 != r.last_blk) begin
						next_r.err   = 1'b1;
						next_r.busy  = 1'b0;
						next_r.state = nmpc_idle;
					end
					// one block per district, same page bits
					if (pwdata[`NMPC_CTRL_MULTI]
					    && (blk0[0] == blk1[0]
					    || r.addr0[16 +: `NMPC_PAGE_BITS]
					    != r.addr1[16 +: `NMPC_PAGE_BITS])) begin
						next_r.err   = 1'b1;
						next_r.busy  = 1'b0;
						next_r.state = nmpc_idle;
					end
				end else if (pwdata[`NMPC_CTRL_GO]) begin
					next_r.pslverr = 1'b1;
				end
			end
			`NMPC_OFF_ADDR0: next_r.addr0[31:0] = pwdata;
			`NMPC_OFF_ADDR1: next_r.addr1[31:0] = pwdata;
			`NMPC_OFF_DATA:  next_r.wptr = r.wptr + 12'h001;
			`NMPC_OFF_LEN: begin
				next_r.len  = pwdata[11:0];
				next_r.wptr = 12'h000;
			end
			default: next_r.pslverr = 1'b1;
			endcase
		end
		next_r.prdata = 32'h0000_0000;
		if (acc && !pwrite) begin
			unique case (paddr)
			`NMPC_OFF_CTRL:   next_r.prdata = {27'h0, 1'b0, r.last,
			                                   r.cache, r.multi, r.busy};
			`NMPC_OFF_ADDR0:  next_r.prdata = r.addr0[31:0];
			`NMPC_OFF_ADDR1:  next_r.prdata = r.addr1[31:0];
			`NMPC_OFF_DATA:   next_r.prdata = {20'h0, r.wptr};
			`NMPC_OFF_STATUS: next_r.prdata = {28'h0, r.rb, r.err,
			                                   r.done, r.busy};
			// current, previous, district bits as read back
			`NMPC_OFF_RESULT: next_r.prdata = {24'h0, r.result};
			`NMPC_OFF_LEN:    next_r.prdata = {20'h0, r.len};
			default:          next_r.pslverr = 1'b1;
			endcase
		end
		// each pin step: phase 0 sets up, phase 1 strobes low, 2 rises
		next_r.phase = (r.state == nmpc_idle) ? 2'd0
		               : (r.phase == 2'd2 ? 2'd0 : r.phase + 2'd1);
		next_r.pins.we_n = !(r.phase == 2'd0 && r.state inside {nmpc_cmd1,
		    nmpc_addr, nmpc_data, nmpc_cmd2, nmpc_stat_cmd, nmpc_reset});
		next_r.pins.re_n = !(r.phase == 2'd0 && r.state == nmpc_stat_rd);
		next_r.pins.ce_n = (r.state == nmpc_idle);
		unique case (r.state)
		nmpc_idle: begin
			next_r.pins.cle     = 1'b0;
			next_r.pins.ale     = 1'b0;
			next_r.pins.dq_oe_n = 1'b1;
		end
		nmpc_cmd1: begin
			cmd = r.second ? `NMPC_CMD_SETUP2 : `NMPC_CMD_SETUP;
			next_r.pins.cle     = 1'b1;
			next_r.pins.dq_out  = cmd;
			next_r.pins.dq_oe_n = 1'b0;
			if (step) begin
				next_r.state = nmpc_addr;
				next_r.cnt   = 12'h000;
			end
		end
		nmpc_addr: begin
			next_r.pins.cle    = 1'b0;
			next_r.pins.ale    = 1'b1;
			next_r.pins.dq_out = addr_byte(a, r.cnt);
			if (step) begin
				next_r.cnt = r.cnt + 12'h001;
				if (r.cnt == 12'(`NMPC_ADDR_CYC - 1)) begin
					next_r.state = nmpc_data;
					next_r.cnt   = 12'h000;
				end
			end
		end
		nmpc_data: begin
			next_r.pins.ale    = 1'b0;
			next_r.pins.dq_out = mem_q;
			if (step) begin
				next_r.cnt = r.cnt + 12'h001;
				if (r.cnt == r.len - 12'h001) begin
					next_r.state = nmpc_cmd2;
				end
			end
		end
		nmpc_cmd2: begin
			// dummy 11h between districts
			if (r.multi && !r.second) begin
				cmd = `NMPC_CMD_DUMMY;
			end else if (r.cache && !r.last) begin
				cmd = `NMPC_CMD_CACHE;
			end else begin
				cmd = `NMPC_CMD_PROG;
			end
			next_r.pins.cle    = 1'b1;
			next_r.pins.dq_out = cmd;
			if (step) begin
				next_r.state = nmpc_wait_rb;
				next_r.cnt   = 12'h000;
			end
		end
		nmpc_wait_rb: begin
			// busy covers cache transfer, program or reset
			next_r.pins.cle     = 1'b0;
			next_r.pins.dq_oe_n = 1'b1;
			next_r.phase        = 2'd0;
			next_r.cnt          = r.cnt + 12'h001;
			// pin may lag the strobe, so give it a few cycles to fall
			if (r.cnt > 12'h008 && r.rb) begin
				if (r.multi && !r.second) begin
					// only 81h may follow 11h here
					next_r.second = 1'b1;
					next_r.state  = nmpc_cmd1;
				end else begin
					next_r.state = nmpc_stat_cmd;
				end
			end
		end
		nmpc_stat_cmd: begin
			// 71h for two-district results
			next_r.pins.cle     = 1'b1;
			next_r.pins.dq_oe_n = 1'b0;
			next_r.pins.dq_out  = r.multi ? `NMPC_CMD_STAT2
			                              : `NMPC_CMD_STAT;
			if (step) begin
				next_r.state = nmpc_stat_rd;
			end
		end
		nmpc_stat_rd: begin
			next_r.pins.cle     = 1'b0;
			next_r.pins.dq_oe_n = 1'b1;
			if (step) begin
				// sample while re_n low; bit0 is the OR
				next_r.result = dq_in;
				next_r.err    = dq_in[`NMPC_SB_FAIL];
				next_r.busy   = 1'b0;
				next_r.done   = 1'b1;
				next_r.state  = nmpc_idle;
				// cached chains stay in the block of addr0
				next_r.chain    = r.cache && !r.last;
				next_r.last_blk = blk_of(r.addr0);
			end
		end
		nmpc_reset: begin
			next_r.pins.cle     = 1'b1;
			next_r.pins.dq_oe_n = 1'b0;
			next_r.pins.dq_out  = `NMPC_CMD_RESET;
			if (step) begin
				next_r.state = nmpc_wait_rb;
				next_r.multi = 1'b0;
				next_r.second = 1'b1;
				next_r.cnt   = 12'h000;
			end
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{state: nmpc_idle, phase: 2'd0, cnt: 12'h000,
			       second: 1'b0, multi: 1'b0, cache: 1'b0, last: 1'b0,
			       busy: 1'b0, done: 1'b0, err: 1'b0,
			       addr0: 40'h0, addr1: 40'h0, len: `NMPC_LEN_RST,
			       wptr: 12'h000, last_blk: 11'h000, chain: 1'b0,
			       result: 8'h00, rb_sync: 3'b000, rb: 1'b0,
			       pins: '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1,
			               we_n: 1'b1, re_n: 1'b1, dq_out: 8'h00,
			               dq_oe_n: 1'b1},
			       prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign flash_pins = r.pins;
	assign prdata     = r.prdata;
	assign pready     = r.pready;
	assign pslverr    = r.pslverr;
endmodule : nmpc_ctrl
`default_nettype wire

//--- src/nmpc_page_mem.sv
// nmpc_page_mem: page staging memory, one byte a word, registered read
// assumes one clock, writer and reader never clash in meaning
`timescale 1ns/1ps
`default_nettype none
module nmpc_page_mem (
	// clock
	input  wire logic        pclk,
	// write side
	input  wire logic        wr_en,
	input  wire logic [11:0] wr_addr,
	input  wire logic [7:0]  wr_data,
	// read side
	input  wire logic [11:0] rd_addr,
	output logic      [7:0]  rd_data
);
	logic [7:0] mem [0:4095];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : nmpc_page_mem
`default_nettype wire

//--- tb/nmpc_ctrl_props.sv
// nmpc_ctrl_props: apb answer and flash pin order checks for nmpc_ctrl
// assumes binding into nmpc_ctrl, flash pins registered on pclk
`timescale 1ns/1ps
`default_nettype none
module nmpc_ctrl_props (
	// clock and reset
	input wire logic                    pclk,
	input wire logic                    presetn,
	// apb
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pready,
	input wire logic                    pslverr,
	// flash
	input wire nmpc_pkg::nmpc_pins_type flash_pins,
	input wire logic                    ready_busy_pin
);
	import nmpc_pkg::*;
	logic [7:0] last_cmd;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// last command byte taken by the flash
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			last_cmd <= 8'hff;
		else if (flash_pins.cle && $rose(flash_pins.we_n))
			last_cmd <= flash_pins.dq_out;
	end
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held over one cycle");
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("answer not after one wait");
	a_pready_src: assert property (pready |-> $past(penable))
		else $error("pready outside access");
	a_err_qual: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_we_pulse: assert property ($fell(flash_pins.we_n) |=> $rose(flash_pins.we_n))
		else $error("write strobe not one cycle");
	a_strobe_excl: assert property (!(!flash_pins.we_n && !flash_pins.re_n))
		else $error("read and write strobes together");
	a_drive_write: assert property (!flash_pins.we_n |-> !flash_pins.dq_oe_n)
		else $error("dq not driven in write strobe");
	a_after_dummy: assert property (
		flash_pins.cle && $rose(flash_pins.we_n) && last_cmd == 8'h11
		|-> flash_pins.dq_out inside {8'h70, 8'h81, 8'hff})
		else $error("bad command after 11h");
	a_confirm_order: assert property (
		flash_pins.cle && $rose(flash_pins.we_n)
		&& flash_pins.dq_out inside {8'h10, 8'h15}
		|-> last_cmd inside {8'h80, 8'h81})
		else $error("confirm without setup");
	a_no_busy_start: assert property (
		flash_pins.cle && $fell(flash_pins.we_n) && flash_pins.dq_out == 8'h80
		|-> ready_busy_pin && $past(ready_busy_pin, 3))
		else $error("program started while busy");
endmodule : nmpc_ctrl_props
bind nmpc_ctrl nmpc_ctrl_props i_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.flash_pins(flash_pins), .ready_busy_pin(ready_busy_pin));
`default_nettype wire

//--- tb/nmpc_ctrl_tb.sv
// nmpc_ctrl_tb: apb sequences against nmpc_ctrl and the flash model
// assumes one wait state per apb access and a 70h/71h read after each op the controller accepts
`include "nmpc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module nmpc_ctrl_tb;
	import nmpc_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic          rb, viol, er;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, rd, ncmd, n;
	logic [7:0]    dq, pcmd;
	logic [1:0]    fail;
	nmpc_pins_type pins;
	int            fail_count, checks;
	nmpc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_pins(pins), .dq_in(dq), .ready_busy_pin(rb));
	nmpc_flash_model i_flash (.pclk(pclk), .pins(pins), .dq(dq),
		.ready_busy_pin(rb), .fail(fail), .pcmd(pcmd), .ncmd(ncmd),
		.viol(viol));
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	// read data and pslverr are taken where pready stands high
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : bus
	task automatic idle;
		do begin
			bus(0, `NMPC_OFF_STATUS, 0);
		end while (rd[`NMPC_ST_BUSY] !== 1'b0);
	endtask : idle
	task automatic op(input logic [31:0] a0, a1, c);
		bus(1, `NMPC_OFF_ADDR0, a0);
		bus(1, `NMPC_OFF_ADDR1, a1);
		bus(1, `NMPC_OFF_LEN, 32'h4);
		for (int i = 0; i < 4; i++) bus(1, `NMPC_OFF_DATA, 32'ha0 + i);
		bus(1, `NMPC_OFF_CTRL, c);
		idle();
	endtask : op
	task automatic res(input logic [7:0] b, input logic e);
		bus(0, `NMPC_OFF_RESULT, 0);
		chk(rd, {24'h0, b});
		bus(0, `NMPC_OFF_STATUS, 0);
		chk({31'h0, rd[`NMPC_ST_ERR]}, {31'h0, e});
	endtask : res
	function automatic logic [31:0] ad(input int b, input int p);
		return 32'((b << 22) | (p << 16));
	endfunction : ad
	task automatic results;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	initial begin
		repeat (60000) @(posedge pclk);
		fail_count++;
		results();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, fail} = '0;
		fail_count = 0;
		checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		bus(0, `NMPC_OFF_LEN, 0);
		chk(rd, 32'h800);
		bus(0, 12'hffc, 0);
		chk({31'h0, er}, 32'h1);
		op(ad(2, 1), 0, 32'h5);
		chk({24'h0, pcmd}, 32'h15);
		res(8'he0, 1'b0);
		n = ncmd;
		// block moved inside a cached chain: no flash traffic
		op(ad(4, 2), 0, 32'h5);
		chk(ncmd, n);
		res(8'he0, 1'b1);
		fail <= 2'b01;
		// next page upward in the same block closes the chain
		op(ad(2, 2), 0, 32'hd);
		chk({24'h0, pcmd}, 32'h10);
		res(8'he1, 1'b1);
		fail <= 2'b10;
		op(ad(2, 3), ad(5, 3), 32'hb);
		res(8'hed, 1'b1);
		fail <= 2'b00;
		op(ad(7, 3), ad(4, 3), 32'hb);
		res(8'hf0, 1'b0);
		// same district, then mismatched page bits
		for (int k = 0; k < 2; k++) begin
			n = ncmd;
			op(ad(2, 3), k ? ad(5, 4) : ad(4, 3), 32'hb);
			chk(ncmd, n);
			res(8'hf0, 1'b1);
		end
		bus(1, `NMPC_OFF_CTRL, 32'h9);
		bus(1, `NMPC_OFF_CTRL, 32'h9);
		chk({31'h0, er}, 32'h1);
		idle();
		bus(1, `NMPC_OFF_CTRL, 32'h10);
		idle();
		chk({24'h0, pcmd}, 32'hff);
		chk({31'h0, viol}, 32'h0);
		results();
	end
endmodule : nmpc_ctrl_tb
`default_nettype wire

//--- tb/nmpc_flash_model.sv
// nmpc_flash_model: behavioural flash program and status engine
// assumes pins registered on pclk; pclk samples the write strobe and times busy periods
`timescale 1ns/1ps
`default_nettype none
module nmpc_flash_model #(
	parameter int CACHE_CYC = 12,
	parameter int PROG_CYC  = 40
) (
	// clock
	input  wire logic                    pclk,
	// flash pins
	input  wire nmpc_pkg::nmpc_pins_type pins,
	output logic [7:0]                   dq,
	output logic                         ready_busy_pin,
	// fault injection, one bit a district, and observation
	input  wire logic [1:0]              fail,
	output logic [7:0]                   pcmd,
	output logic [31:0]                  ncmd,
	output logic                         viol
);
	import nmpc_pkg::*;
	logic [7:0] cmd, hold, sb;
	logic [1:0] cur, prev;
	logic       we_q, multi, after11, rdy;
	int         busy;
	initial begin
		{cmd, hold, pcmd, ncmd, cur, prev} = '0;
		{we_q, multi, after11, viol, busy} = '0;
	end
	assign rdy = (busy == 0);
	assign ready_busy_pin = rdy;
	assign sb = (cmd == 8'h71) ? {2'b11, rdy, prev, cur, |cur}
		: {1'b1, rdy, rdy, 3'b000, |prev, |cur};
	// a released bus shows the inverse of the status byte held at the last rise of re_n
	assign dq = pins.re_n ? ~hold : sb;
	always @(posedge pins.re_n) hold <= sb;
	always @(posedge pclk) begin
		we_q <= pins.we_n;
		if (busy > 0) busy <= busy - 1;
		if (pins.we_n && !we_q && !pins.ce_n && pins.cle) begin
			cmd <= pins.dq_out;
			ncmd <= ncmd + 1;
			if (after11 && !(pins.dq_out inside {8'h70, 8'h81, 8'hff}))
				viol <= 1'b1;
			if (pins.dq_out == 8'h11) after11 <= 1'b1;
			if (pins.dq_out inside {8'h81, 8'hff}) after11 <= 1'b0;
			if (pins.dq_out inside {8'h80, 8'h81}) multi <= pins.dq_out[0];
			if (pins.dq_out inside {8'h10, 8'h15, 8'hff}) pcmd <= pins.dq_out;
			if (pins.dq_out inside {8'h10, 8'h15}) begin
				prev <= cur;
				cur <= fail & {multi, 1'b1};
				busy <= pins.dq_out[2] ? CACHE_CYC : PROG_CYC;
			end
			if (pins.dq_out == 8'hff) busy <= 2;
		end
	end
endmodule : nmpc_flash_model
`default_nettype wire
